// ===== src/adcseq_consts.svh
// constants for the converter sequencer: field widths, phase lengths, clamp codes
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH
`define ADCSEQ_CLK_HZ        20000000
`define ADCSEQ_CONV_HALF     10'h01b
`define ADCSEQ_SAMP_BASE     10'h002
`define ADCSEQ_FMT_LAST      1'h1
`define ADCSEQ_WARM_BASE     10'h010
`define ADCSEQ_WARM_MAXSEL   3'h5
`define ADCSEQ_ACC_DIRECT    3'h4
`define ADCSEQ_RES_W         5'h10
`define ADCSEQ_SE12_MAX      14'sh0fff
`define ADCSEQ_SE10_MAX      14'sh03ff
`define ADCSEQ_SE_MIN        14'sh0000
`define ADCSEQ_DF12_MAX      14'sh07ff
`define ADCSEQ_DF12_MIN      14'sh3800
`define ADCSEQ_DF10_MAX      14'sh01ff
`define ADCSEQ_DF10_MIN      14'sh3e00
`define ADCSEQ_BITS12        5'h0c
`define ADCSEQ_BITS10        5'h0a
`endif

// ===== src/adcseq_pkg.sv
// types shared by the converter sequencer modules
`default_nettype none
package adcseq_pkg;
  typedef enum logic [2:0] {
    ADCSEQ_IDLE    = 3'b000,
    ADCSEQ_START   = 3'b001,
    ADCSEQ_WARMUP  = 3'b010,
    ADCSEQ_SAMPLE  = 3'b011,
    ADCSEQ_CONVERT = 3'b100,
    ADCSEQ_FORMAT  = 3'b101
  } adcseq_state_t;
  typedef logic signed [13:0] adcseq_raw_t;
  typedef logic signed [19:0] adcseq_acc_t;
endpackage : adcseq_pkg
`default_nettype wire

// ===== src/adcseq_fmt_if.sv
// carrier between the sequencer and its result formatter
`default_nettype none
interface adcseq_fmt_if;
  import adcseq_pkg::*;
  adcseq_raw_t raw_code;
  logic        differential;
  logic        res_10bit;
  logic        left_justify;
  logic [2:0]  acc_sel;
  adcseq_acc_t acc_sum;
  adcseq_raw_t clamped;
  logic [15:0] result;
  modport seq (output raw_code, differential, res_10bit, left_justify, acc_sel, acc_sum,
               input clamped, result);
  modport fmt (input raw_code, differential, res_10bit, left_justify, acc_sel, acc_sum,
               output clamped, result);
endinterface : adcseq_fmt_if
`default_nettype wire

// ===== src/adcseq_fmt.sv
// result formatter: clamps each sample and justifies or truncates the sum
`include "adcseq_consts.svh"
`default_nettype none
module adcseq_fmt (
  adcseq_fmt_if.fmt f   // formatter side of the carrier
);
  import adcseq_pkg::*;

  adcseq_raw_t hi_lim;
  adcseq_raw_t lo_lim;
  logic [4:0]  width;
  logic [4:0]  lshift;
  logic [2:0]  rshift;

  // clamp limits depend on mode and resolution
  always_comb
  begin
    if (f.differential)
    begin
      hi_lim = f.res_10bit ? `ADCSEQ_DF10_MAX : `ADCSEQ_DF12_MAX;
      lo_lim = f.res_10bit ? `ADCSEQ_DF10_MIN : `ADCSEQ_DF12_MIN;
    end
    else
    begin
      hi_lim = f.res_10bit ? `ADCSEQ_SE10_MAX : `ADCSEQ_SE12_MAX;
      lo_lim = `ADCSEQ_SE_MIN;
    end
  end

  // out-of-range codes saturate rather than wrap
  always_comb
  begin
    if (f.raw_code > hi_lim)
      f.clamped = hi_lim;
    else if (f.raw_code < lo_lim)
      f.clamped = lo_lim;
    else
      f.clamped = f.raw_code;
  end

  // sum width grows one bit per doubling of the sample count
  always_comb
  begin
    width  = (f.res_10bit ? `ADCSEQ_BITS10 : `ADCSEQ_BITS12) + {2'h0, f.acc_sel};
    lshift = `ADCSEQ_RES_W - width;
    rshift = f.acc_sel - `ADCSEQ_ACC_DIRECT;
    if (f.acc_sel > `ADCSEQ_ACC_DIRECT)
      f.result = 16'(f.acc_sum >>> rshift);
    else if (f.left_justify)
      f.result = 16'(f.acc_sum <<< lshift);
    else
      f.result = 16'(f.acc_sum);
  end
endmodule : adcseq_fmt
`default_nettype wire

// ===== src/adcseq_top.sv
// converter sequencer: clock prescaler, phase timing, accumulation and result capture
`include "adcseq_consts.svh"
`default_nettype none
module adcseq_top (
  input  wire logic              clock,                    // peripheral clock, 20 MHz
  input  wire logic              reset,                    // async reset, active high
  input  wire logic              enable,                   // converter enable
  input  wire logic              start_conversion_write,   // one-cycle write of one to the command bit
  input  wire logic              start_event,              // event line, asynchronous
  input  wire logic              event_start_enable,       // allow event starts
  input  wire logic              continuous_mode,          // free-running restart
  input  wire logic              differential,             // differential conversion
  input  wire logic              res_10bit,                // 10-bit resolution
  input  wire logic              left_justify,             // left-justify result
  input  wire logic [2:0]        clock_divider_select,     // divide by 2^(n+1)
  input  wire logic [2:0]        accumulation_count_select,// 2^n samples
  input  wire logic [3:0]        sample_delay_select,      // extra sample cycles
  input  wire logic [7:0]        sample_length_extend,     // extra sample cycles
  input  wire logic [2:0]        warmup_delay_select,      // warm-up length code
  input  wire adcseq_pkg::adcseq_raw_t core_code,          // code from analog core
  input  wire logic              result_ready_flag_clear,  // clear ready flag
  output logic                   start_conversion_cmd,     // command bit readback
  output logic                   result_ready_flag,        // sticky ready flag
  output logic                   result_ready_event,       // one-cycle ready event
  output logic [15:0]            converted_value,          // result register
  output logic                   sample_hold,              // analog core sampling
  output logic                   convert_active            // analog core converting
);
  import adcseq_pkg::*;

  adcseq_fmt_if fbus ();
  adcseq_state_t state_r;
  adcseq_state_t state_nxt;
  logic [7:0]  clock_divider_select_cnt_r;
  logic [9:0]  phase_cnt_r;
  logic [9:0]  warm_cnt_r;
  logic        warm_done_r;
  logic [7:0]  samp_idx_r;
  logic        fmt_cnt_r;
  adcseq_acc_t acc_r;
  logic [2:0]  ev_sync_r;
  logic        ev_level_r;
  logic        ev_rise;
  logic        trigger;
  logic        half_tick;
  logic        clock_divider_select_run;
  logic [7:0]  half_len;
  logic [9:0]  samp_half;
  logic        last_sample;
  logic        fmt_last;

  // warm-up length in half conversion cycles; code 0 means none
  function automatic logic [9:0] warm_half(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > `ADCSEQ_WARM_MAXSEL) ? `ADCSEQ_WARM_MAXSEL : sel;
    warm_half = (s == 3'h0) ? 10'h000 : 10'((`ADCSEQ_WARM_BASE << (s - 3'h1)) << 1);
  endfunction : warm_half

  assign fbus.raw_code     = core_code;
  assign fbus.differential = differential;
  assign fbus.res_10bit    = res_10bit;
  assign fbus.left_justify = left_justify;
  assign fbus.acc_sel      = accumulation_count_select;
  assign fbus.acc_sum      = acc_r;

  adcseq_fmt u_fmt (
    .f (fbus.fmt)
  );

  // three-stage synchroniser; only stages two and three are compared
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ev_sync_r  <= 3'h0;
      ev_level_r <= 1'h0;
    end
    else
    begin
      ev_sync_r <= {ev_sync_r[1:0], start_event};
      if (ev_sync_r[1] == ev_sync_r[2])
        ev_level_r <= ev_sync_r[2];
    end
  end

  assign ev_rise = (ev_sync_r[1] == ev_sync_r[2]) && ev_sync_r[2] && !ev_level_r;
  assign trigger = enable && (start_conversion_write || (event_start_enable && ev_rise));

  // half conversion clock ticks; counter held at zero when not timing a phase
  assign half_len  = 8'h01 << clock_divider_select;
  assign clock_divider_select_run = (state_r == ADCSEQ_WARMUP) || (state_r == ADCSEQ_SAMPLE) || (state_r == ADCSEQ_CONVERT);
  assign half_tick = clock_divider_select_run && (clock_divider_select_cnt_r == half_len - 8'h01);
  assign samp_half = 10'((`ADCSEQ_SAMP_BASE + {6'h0, sample_delay_select} + {2'h0, sample_length_extend}) << 1);
  assign last_sample = (samp_idx_r == 8'((8'h01 << accumulation_count_select) - 8'h01));
  assign fmt_last  = (fmt_cnt_r == `ADCSEQ_FMT_LAST);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      clock_divider_select_cnt_r <= 8'h00;
    else if (!clock_divider_select_run || half_tick)
      clock_divider_select_cnt_r <= 8'h00;
    else
      clock_divider_select_cnt_r <= clock_divider_select_cnt_r + 8'h01;
  end

  // phase sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ADCSEQ_IDLE:
        if (trigger)
          state_nxt = ADCSEQ_START;
      ADCSEQ_START:
        if (warm_done_r || warm_half(warmup_delay_select) == 10'h000)
          state_nxt = ADCSEQ_SAMPLE;
        else
          state_nxt = ADCSEQ_WARMUP;
      ADCSEQ_WARMUP:
        if (half_tick && warm_cnt_r == 10'h001)
          state_nxt = ADCSEQ_SAMPLE;
      ADCSEQ_SAMPLE:
        if (half_tick && phase_cnt_r == samp_half - 10'h001)
          state_nxt = ADCSEQ_CONVERT;
      ADCSEQ_CONVERT:
        if (half_tick && phase_cnt_r == `ADCSEQ_CONV_HALF - 10'h001)
          state_nxt = ADCSEQ_FORMAT;
      ADCSEQ_FORMAT:
        if (fmt_last)
        begin
          if (!last_sample)
            state_nxt = ADCSEQ_SAMPLE;
          else if (continuous_mode && enable)
            state_nxt = ADCSEQ_START;
          else
            state_nxt = ADCSEQ_IDLE;
        end
      default:
        state_nxt = ADCSEQ_IDLE;
    endcase
    if (!enable)
      state_nxt = ADCSEQ_IDLE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_r <= ADCSEQ_IDLE;
    else
      state_r <= state_nxt;
  end

  // phase counter restarts on each phase change
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      phase_cnt_r <= 10'h000;
    else if (state_nxt != state_r)
      phase_cnt_r <= 10'h000;
    else if (half_tick)
      phase_cnt_r <= phase_cnt_r + 10'h001;
  end

  // format phase lasts two peripheral cycles
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      fmt_cnt_r <= 1'h0;
    else if (state_r == ADCSEQ_FORMAT)
      fmt_cnt_r <= !fmt_cnt_r;
    else
      fmt_cnt_r <= 1'h0;
  end

  // warm-up runs once per enable; loaded at the first start, so an enable
  // already high when reset lifts still waits for the analog side
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      warm_cnt_r  <= 10'h000;
      warm_done_r <= 1'h0;
    end
    else if (!enable)
    begin
      warm_cnt_r  <= 10'h000;
      warm_done_r <= 1'h0;
    end
    else if (state_r == ADCSEQ_START && !warm_done_r)
      warm_cnt_r <= warm_half(warmup_delay_select);
    else if (state_r == ADCSEQ_WARMUP && half_tick)
    begin
      warm_cnt_r <= warm_cnt_r - 10'h001;
      if (warm_cnt_r == 10'h001)
        warm_done_r <= 1'h1;
    end
    else if (state_r == ADCSEQ_SAMPLE)
      warm_done_r <= 1'h1;
  end

  // accumulator and sample index; the clamped code is added in the first format cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      acc_r      <= 20'sh00000;
      samp_idx_r <= 8'h00;
    end
    else if (state_r == ADCSEQ_START)
    begin
      acc_r      <= 20'sh00000;
      samp_idx_r <= 8'h00;
    end
    else if (state_r == ADCSEQ_FORMAT && !fmt_last)
      acc_r <= acc_r + 20'(fbus.clamped);
    else if (state_r == ADCSEQ_FORMAT && fmt_last && !last_sample)
      samp_idx_r <= samp_idx_r + 8'h01;
  end

  // result register and event update at the end of the operation; command bit sets at the start and clears on return to idle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      converted_value      <= 16'h0000;
      result_ready_event   <= 1'h0;
      start_conversion_cmd <= 1'h0;
    end
    else
    begin
      result_ready_event <= 1'h0;
      if (state_r == ADCSEQ_FORMAT && fmt_last && last_sample)
      begin
        converted_value    <= fbus.result;
        result_ready_event <= 1'h1;
      end
      if (state_nxt == ADCSEQ_IDLE)
        start_conversion_cmd <= 1'h0;
      else if (state_nxt == ADCSEQ_START || state_r != ADCSEQ_IDLE)
        start_conversion_cmd <= 1'h1;
    end
  end

  // sticky flag; a completion in the clearing cycle still sets it
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      result_ready_flag <= 1'h0;
    else if (state_r == ADCSEQ_FORMAT && fmt_last && last_sample)
      result_ready_flag <= 1'h1;
    else if (result_ready_flag_clear)
      result_ready_flag <= 1'h0;
  end

  // analog core strobes follow the next phase so they line up with it
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sample_hold    <= 1'h0;
      convert_active <= 1'h0;
    end
    else
    begin
      sample_hold    <= (state_nxt == ADCSEQ_SAMPLE);
      convert_active <= (state_nxt == ADCSEQ_CONVERT);
    end
  end
endmodule : adcseq_top
`default_nettype wire

// ===== verif/adcseq_core_model.sv
// behavioural analog core answering the sequencer
`default_nettype none
module adcseq_core_model (
  input  wire logic                    clock,          // peripheral clock
  input  wire logic                    reset,          // async reset
  input  wire logic                    convert_active, // core converting
  input  wire adcseq_pkg::adcseq_raw_t code_value,     // code to deliver
  output var adcseq_pkg::adcseq_raw_t  core_code       // code to sequencer
);
  import adcseq_pkg::*;
  logic hold_r;
  // code stays valid one cycle past conversion, the format read slot
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      hold_r <= 1'b0;
    else
      hold_r <= convert_active;
  end
  // inverse outside that slot so a late read shows up wrong
  assign core_code = (convert_active || hold_r) ? code_value : ~code_value;
endmodule : adcseq_core_model
`default_nettype wire

// ===== verif/adcseq_top_properties.sv
// timing and flag checks on the sequencer ports
`default_nettype none
module adcseq_top_properties (
  input wire logic       clock,                     // peripheral clock
  input wire logic       reset,                     // async reset
  input wire logic       enable,                    // converter enable
  input wire logic       start_conversion_write,    // command write
  input wire logic [2:0] clock_divider_select,      // prescaler code
  input wire logic [2:0] accumulation_count_select, // sample count code
  input wire logic [3:0] sample_delay_select,       // extra sample cycles
  input wire logic [7:0] sample_length_extend,      // extra sample cycles
  input wire logic [2:0] warmup_delay_select,       // warm-up code
  input wire logic       result_ready_flag_clear,   // flag clear
  input wire logic       start_conversion_cmd,      // command readback
  input wire logic       result_ready_flag,         // sticky flag
  input wire logic       result_ready_event,        // ready pulse
  input wire logic       sample_hold,               // sampling
  input wire logic       convert_active             // converting
);
  logic [31:0] samp_n;
  logic [31:0] conv_n;
  logic [7:0]  nsamp_r;
  logic        sh_q;
  // phase lengths counted in peripheral cycles, zero while phase is off
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      samp_n <= 32'h0;
      conv_n <= 32'h0;
    end
    else
    begin
      samp_n <= sample_hold ? samp_n + 32'h1 : 32'h0;
      conv_n <= convert_active ? conv_n + 32'h1 : 32'h0;
    end
  end
  // samples per operation; cleared after each ready pulse for back-to-back runs
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      nsamp_r <= 8'h0;
      sh_q    <= 1'b0;
    end
    else
    begin
      sh_q    <= sample_hold;
      nsamp_r <= (!start_conversion_cmd || result_ready_event) ? 8'h0 : nsamp_r + 8'(sample_hold && !sh_q);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_cmd_on_write: assert property (enable && start_conversion_write && !start_conversion_cmd |=> start_conversion_cmd)
    else $error("command bit not set after write");
  a_sample_starts: assert property ($rose(start_conversion_cmd) && warmup_delay_select == 3'h0 |=> sample_hold)
    else $error("sampling late after start");
  a_sample_len: assert property ($fell(sample_hold) |-> convert_active
    && samp_n == ((32'h2 + sample_delay_select + sample_length_extend) << (clock_divider_select + 1)))
    else $error("sampling length wrong");
  a_convert_len: assert property ($fell(convert_active) |-> conv_n == (32'h1b << clock_divider_select))
    else $error("conversion length wrong");
  a_format_two: assert property ($fell(convert_active) && accumulation_count_select == 3'h0 |-> ##2 result_ready_event)
    else $error("format phase not two cycles");
  a_event_pulse: assert property (result_ready_event |-> result_ready_flag ##1 !result_ready_event)
    else $error("ready event or flag wrong");
  a_cmd_clears: assert property ($fell(start_conversion_cmd) && enable |-> result_ready_event)
    else $error("command bit fell without completion");
  a_flag_clear: assert property (result_ready_flag_clear |=> !result_ready_flag || result_ready_event)
    else $error("flag not cleared");
  a_accum_once: assert property (result_ready_event |-> nsamp_r == (8'h1 << accumulation_count_select))
    else $error("ready event sample count wrong");
  c_accum: cover property (result_ready_event && accumulation_count_select == 3'h5);
  c_cont: cover property (result_ready_event && start_conversion_cmd);
  c_clock_divider_select: cover property ($fell(sample_hold) && clock_divider_select == 3'h2);
endmodule : adcseq_top_properties
bind adcseq_top adcseq_top_properties adcseq_top_properties_i (.clock, .reset, .enable, .start_conversion_write,
  .clock_divider_select, .accumulation_count_select, .sample_delay_select, .sample_length_extend,
  .warmup_delay_select, .result_ready_flag_clear, .start_conversion_cmd, .result_ready_flag,
  .result_ready_event, .sample_hold, .convert_active);
`default_nettype wire

// ===== verif/adcseq_top_bench.sv
// self-checking bench for the converter sequencer
`default_nettype none
module adcseq_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import adcseq_pkg::*;
  logic        clock = 0, reset = 1, enable = 0, start_conversion_write = 0, start_event = 0;
  logic        event_start_enable = 0, continuous_mode = 0, differential = 0, res_10bit = 0;
  logic        left_justify = 0, result_ready_flag_clear = 0;
  logic [2:0]  clock_divider_select = 0, accumulation_count_select = 0, warmup_delay_select = 1;
  logic [3:0]  sample_delay_select = 0;
  logic [7:0]  sample_length_extend = 0;
  adcseq_raw_t code_value = 0, core_code;
  logic        start_conversion_cmd, result_ready_flag, result_ready_event, sample_hold, convert_active;
  logic [15:0] converted_value;
  int          miscompares = 0, n_compared = 0, lat;
  adcseq_top adcseq_top_i (.clock, .reset, .enable, .start_conversion_write, .start_event, .event_start_enable,
    .continuous_mode, .differential, .res_10bit, .left_justify, .clock_divider_select,
    .accumulation_count_select, .sample_delay_select, .sample_length_extend, .warmup_delay_select,
    .core_code, .result_ready_flag_clear, .start_conversion_cmd, .result_ready_flag, .result_ready_event,
    .converted_value, .sample_hold, .convert_active);
  adcseq_core_model adcseq_core_model_i (.clock, .reset, .convert_active, .code_value, .core_code);
  // 20 MHz peripheral clock
  always #25 clock = ~clock;
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // bounded wait, so a lost completion cannot hang the run
  task wait_done;
    int n;
    n = 0;
    while (result_ready_event !== 1'b1 && n < 9000)
    begin
      @(negedge clock);
      n++;
    end
    check("result_ready_event", 16'h1, 16'(result_ready_event));
  endtask : wait_done
  task run(input logic ev, d, r, l, input logic [2:0] a, input adcseq_raw_t c, input logic [15:0] e);
    differential = d;
    res_10bit = r;
    left_justify = l;
    accumulation_count_select = a;
    code_value = c;
    start_event = ev;
    start_conversion_write = !ev;
    @(negedge clock);
    start_conversion_write = 1'b0;
    lat = 0;
    while (sample_hold !== 1'b1 && lat < 2000)
    begin
      @(negedge clock);
      lat++;
    end
    wait_done;
    start_event = 1'b0;
    check("converted_value", e, converted_value);
    @(negedge clock);
  endtask : run
  task print_verdict;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    enable = 1'b1;
    run(0, 0, 0, 0, 3'h0, 14'h0123, 16'h0123);
    check("warm-up wait", 16'h1, 16'(lat >= 32));
    warmup_delay_select = 3'h0;
    run(0, 0, 0, 1, 3'h0, 14'h0123, 16'h1230);
    run(0, 0, 0, 0, 3'h0, 14'h1fff, 16'h0fff);
    run(0, 0, 0, 0, 3'h0, 14'h3f00, 16'h0000);
    run(0, 0, 1, 0, 3'h0, 14'h0500, 16'h03ff);
    run(0, 0, 1, 1, 3'h0, 14'h03ff, 16'hffc0);
    run(0, 1, 0, 0, 3'h0, 14'h3ffb, 16'hfffb);
    run(0, 1, 0, 1, 3'h0, 14'h3ffb, 16'hffb0);
    run(0, 1, 0, 0, 3'h0, 14'h0900, 16'h07ff);
    run(0, 1, 0, 0, 3'h0, 14'h3000, 16'hf800);
    run(0, 1, 1, 0, 3'h0, 14'h0200, 16'h01ff);
    run(0, 0, 0, 1, 3'h1, 14'h0100, 16'h1000);
    run(0, 0, 0, 0, 3'h5, 14'h0fff, 16'hfff0);
    // slowest divider kept above the minimum conversion rate
    clock_divider_select = 3'h2;
    sample_delay_select = 4'h1;
    sample_length_extend = 8'h02;
    run(0, 0, 0, 0, 3'h0, 14'h0055, 16'h0055);
    clock_divider_select = 3'h0;
    sample_delay_select = 4'h0;
    sample_length_extend = 8'h00;
    event_start_enable = 1'b1;
    run(1, 0, 0, 0, 3'h0, 14'h0077, 16'h0077);
    event_start_enable = 1'b0;
    // continuous with two-sample accumulation
    accumulation_count_select = 3'h1;
    continuous_mode = 1'b1;
    code_value = 14'h0100;
    start_conversion_write = 1'b1;
    @(negedge clock);
    start_conversion_write = 1'b0;
    repeat (2)
    begin
      wait_done;
      check("converted_value", 16'h0200, converted_value);
      check("start_conversion_cmd", 16'h1, 16'(start_conversion_cmd));
      @(negedge clock);
    end
    continuous_mode = 1'b0;
    wait_done;
    @(negedge clock);
    check("start_conversion_cmd", 16'h0, 16'(start_conversion_cmd));
    check("result_ready_flag", 16'h1, 16'(result_ready_flag));
    result_ready_flag_clear = 1'b1;
    @(negedge clock);
    result_ready_flag_clear = 1'b0;
    check("result_ready_flag", 16'h0, 16'(result_ready_flag));
    print_verdict;
  end
  // watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #(40000 * 50);
    miscompares++;
    print_verdict;
  end
endmodule : adcseq_top_bench
`default_nettype wire
